// file: tb/exec_props.sv
// Port assertions for the shift, status and misc executor.
`default_nettype none
module exec_props #(
    parameter [7:0] CLK_PER_MC = 8'h32
) (
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic [3:0]  reg_addr,
    input wire logic        reg_write,
    input wire logic        fetch_req,
    input wire logic [15:0] fetch_addr,
    input wire logic        fetch_ack,
    input wire logic [7:0]  fetch_data,
    input wire logic        int_req,
    input wire logic        int_take,
    input wire logic        halt_flag
);
timeunit 1ns;
timeprecision 1ns;
logic [7:0]  run;
logic [7:0]  op;
logic [15:0] pc;
logic        seen;
wire         hs = fetch_req && fetch_ack;
////////////////////////////////////////////////////////////
// Last fetched byte and address; a PC write breaks the chain.
always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
        run <= 8'h00;
        op <= 8'hFF;
        pc <= 16'h0000;
        seen <= 1'b0;
    end else begin
        run <= halt_flag ? run + 8'h01 : 8'h00;
        if (hs) begin
            op <= fetch_data;
            pc <= fetch_addr;
            seen <= 1'b1;
        end else if (reg_write && reg_addr inside {4'h3, 4'h4}) begin
            seen <= 1'b0;
        end
    end
end
default clocking dc @(posedge clock);
endclocking
default disable iff (!rst_n);
req_hold_a: assert property (fetch_req && !fetch_ack |=>
    fetch_req && $stable(fetch_addr)) else $error("fetch not held");
exec_gap_a: assert property (hs |=> !fetch_req [*8])
    else $error("fetch too soon");
pc_step_a: assert property (hs && seen |->
    fetch_addr == pc + (op[7] ? 16'h0002 : 16'h0001)) else $error("pc");
halt_len_a: assert property ($fell(halt_flag) |-> run == CLK_PER_MC)
    else $error("halt length");
halt_op_a: assert property (halt_flag |-> op == 8'h00)
    else $error("halt on other code");
halt_late_a: assert property (hs && fetch_data == 8'h00 |=>
    !halt_flag [*8]) else $error("halt too early");
take_cause_a: assert property (int_take |->
    $past(int_req) ##1 !int_take) else $error("bad take");
take_defer_a: assert property (int_take |-> op != 8'h05)
    else $error("take not deferred");
cover property (hs && fetch_data == 8'h00);
cover property (int_take);
cover property (hs && seen);
endmodule
`default_nettype wire

// file: tb/fetch_mem.sv
// Program memory model that answers opcode fetches.
`default_nettype none
module fetch_mem (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        fetch_req,
    input  wire logic [15:0] fetch_addr,
    input  wire logic [7:0]  op_byte,
    input  wire logic [2:0]  delay,
    output var  logic        fetch_ack,
    output var  logic [7:0]  fetch_data,
    output var  logic [15:0] last_addr,
    output var  int          served
);
timeunit 1ns;
timeprecision 1ns;
logic [2:0] wait_cnt;
// Answer after the commanded stall; idle data toggles so a stale
// byte can pass for a fresh one only if the new byte equals the last one or its complement.
always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
        fetch_ack <= 1'b0;
        fetch_data <= 8'hA5;
        last_addr <= 16'h0000;
        wait_cnt <= 3'h0;
        served <= 0;
    end else if (fetch_req && !fetch_ack && wait_cnt == delay) begin
        fetch_ack <= 1'b1;
        fetch_data <= op_byte;
        last_addr <= fetch_addr;
        wait_cnt <= 3'h0;
        served <= served + 1;
    end else begin
        fetch_ack <= 1'b0;
        fetch_data <= ~fetch_data;
        wait_cnt <= (fetch_req && !fetch_ack) ? wait_cnt + 3'h1 : 3'h0;
    end
end
endmodule
`default_nettype wire

// file: tb/shift_status_misc_exec_test.sv
// Self-checking bench for the shift, status and misc executor.
`default_nettype none
module shift_status_misc_exec_test;
timeunit 1ns;
timeprecision 1ns;
logic [3:0]  addr = 4'h0;
logic [7:0]  wdata = 8'h00;
logic [7:0]  op = 8'h00;
logic [2:0]  delay = 3'h0;
logic        clock = 1'b0;
logic        rst_n = 1'b0;
logic        wr_s = 1'b0;
logic        rd_s = 1'b0;
logic        sa = 1'b0;
logic        sb = 1'b0;
logic        irq = 1'b0;
wire  [7:0]  rdata;
wire  [7:0]  fdata;
wire  [15:0] faddr;
wire  [15:0] maddr;
wire  [2:0]  fl;
wire         freq;
wire         fack;
wire         take;
wire         halt;
int          served;
int          seed = 66014;
int          cyc = 0;
int          halts = 0;
int          takes = 0;
int          num_errors = 0;
int          total_checks = 0;
logic [7:0]  ops [13] = '{8'h00, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
                          8'h08, 8'h1D, 8'h1E, 8'h1F, 8'h01, 8'h80};
always #10 clock = ~clock;
// Short microcycles keep the run brief; expectations use 4 clocks.
shift_status_misc_exec #(.CLK_PER_MC(8'h04)) shift_status_misc_exec_inst (
    .clock(clock), .rst_n(rst_n), .reg_addr(addr), .reg_wdata(wdata),
    .reg_write(wr_s), .reg_read(rd_s), .reg_rdata(rdata),
    .fetch_req(freq), .fetch_addr(faddr), .fetch_ack(fack),
    .fetch_data(fdata), .sense_a(sa), .sense_b(sb), .int_req(irq),
    .int_take(take), .halt_flag(halt), .flag_out(fl));
fetch_mem fetch_mem_inst (
    .clock(clock), .rst_n(rst_n), .fetch_req(freq), .fetch_addr(faddr),
    .op_byte(op), .delay(delay), .fetch_ack(fack), .fetch_data(fdata),
    .last_addr(maddr), .served(served));
// Outside logic just counts clocks, clocks with halt high, and take pulses.
always @(posedge clock) begin
    cyc <= cyc + 1;
    halts <= halts + int'(halt);
    takes <= takes + int'(take);
end
task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clock);
    wr_s <= 1'b0;
endtask
task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clock);
    rd_s <= 1'b0;
    #1 d = rdata;
endtask
task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
        num_errors++;
        $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
endtask
task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
endtask
task automatic await_fetch(input int n);
    for (int i = 0; served < n; i++) begin
        if (i == 400) begin
            num_errors++;
            tally_and_finish();
        end
        @(posedge clock);
    end
endtask
// Polls the state register; a stuck core ends the run instead of hanging.
task automatic await_stop;
    logic [7:0] g;
    for (int i = 0; i < 300; i++) begin
        rd(4'h5, g);
        if (g[1:0] === 2'b00) return;
    end
    num_errors++;
    tally_and_finish();
endtask
// Result {microcycles, work, flags as read, pc} of one instruction.
function automatic logic [35:0] model(input logic [7:0] o, input logic [7:0] w,
    input logic [7:0] f, input logic [15:0] pc);
    logic [3:0] n;
    n = 4'h5;
    pc = pc + 16'h0001;
    case (o)
        8'h00: n = 4'h8;
        8'h02: f[7] = 1'b0;
        8'h03: f[7] = 1'b1;
        8'h04, 8'h05: begin
            n = 4'h6;
            f[3] = o[0];
        end
        8'h06: w = f;
        8'h07: begin
            n = 4'h6;
            f = {w[7:6], f[5:4], w[3:0]};
        end
        8'h1D: w = {f[7], w[7:1]};
        8'h1E: w = {w[0], w[7:1]};
        8'h1F: {w, f[7]} = {f[7], w};
        default: if (o[7]) begin
            n = 4'hA;
            pc = pc + 16'h0001;
        end
    endcase
    return {n, w, f, pc};
endfunction
task automatic run_one(input logic [7:0] o);
    logic [35:0] e;
    logic [15:0] pc;
    logic [7:0]  w;
    logic [7:0]  f;
    logic [7:0]  g;
    logic [7:0]  h;
    logic [5:0]  r;
    logic        x;
    int          n;
    int          c;
    int          s0;
    int          h0;
    int          k0;
    w = 8'($random(seed));
    f = 8'($random(seed));
    pc = 16'($random(seed));
    r = 6'($random(seed));
    e = model(o, w, {f[7:6], r[3], r[4], f[3:0]}, pc);
    x = r[5] && e[19] && o != 8'h05 && !(o == 8'h07 && !f[3]);
    @(posedge clock);
    {irq, sa, sb, delay} <= r;
    op <= o;
    wr(4'h1, w);
    wr(4'h2, f);
    wr(4'h3, pc[7:0]);
    wr(4'h4, pc[15:8]);
    s0 = served;
    h0 = halts;
    k0 = takes;
    wr(4'h0, 8'h01);
    await_fetch(s0 + 1);
    c = cyc;
    wr(4'h0, 8'h00);
    wr(4'h1, ~w);
    await_stop();
    c = cyc - c;
    n = int'(e[35:32]);
    chk("exec_time", 16'(n),
        (c >= 4*n-5 && c <= 4*n+5) ? 16'(n) : 16'(c));
    rd(4'h1, g);
    chk("work", {8'h00, e[31:24]}, {8'h00, g});
    rd(4'h2, g);
    chk("flags", {8'h00, e[23:16]}, {8'h00, g});
    chk("flag_out", {13'h0, e[18:16]}, {13'h0, fl});
    rd(4'h3, g);
    rd(4'h4, h);
    chk("pc", e[15:0], {h, g});
    chk("fetch_addr", pc, maddr);
    chk("halt", o == 8'h00 ? 16'h0004 : 16'h0000, 16'(halts - h0));
    chk("take", {15'h0, x}, 16'(takes - k0));
    $display("test %h done", o);
endtask
task automatic chain(input logic [7:0] o, input logic x);
    logic [7:0] g;
    logic [7:0] h;
    int         s0;
    int         k0;
    @(posedge clock);
    op <= o;
    irq <= 1'b1;
    wr(4'h3, 8'h00);
    wr(4'h4, 8'h01);
    s0 = served;
    k0 = takes;
    wr(4'h0, 8'h01);
    await_fetch(s0 + 3);
    wr(4'h0, 8'h00);
    await_stop();
    rd(4'h3, g);
    rd(4'h4, h);
    chk("chain_pc", 16'h0100 + 16'(served - s0), {h, g});
    chk("chain_take", x ? 16'(served - s0) : 16'h0, 16'(takes - k0));
    $display("chain %h done", o);
endtask
initial begin
    logic [7:0] g;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    wr(4'hF, 8'hFF);
    wr(4'h5, 8'hFF);
    rd(4'hF, g);
    chk("unmapped", 16'h0000, {8'h00, g});
    rd(4'h5, g);
    chk("state", 16'h0000, {8'h00, g});
    for (int i = 0; i < 40; i++) run_one(i < 13 ? ops[i] : 8'($random(seed)));
    chain(8'h05, 1'b0);
    chain(8'h08, 1'b1);
    tally_and_finish();
end
endmodule
bind shift_status_misc_exec exec_props #(.CLK_PER_MC(CLK_PER_MC))
    exec_props_inst (
    .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_write(reg_write), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
    .fetch_ack(fetch_ack), .fetch_data(fetch_data), .int_req(int_req),
    .int_take(int_take), .halt_flag(halt_flag));
`default_nettype wire

// file: verilog/shift_status_misc_exec.v
// Executor for the shift, status and miscellaneous single-byte instructions.
//
// Our own choices: the placing of the registers and the strobed register port.
`default_nettype none
`include "shift_status_misc_exec_defines.vh"

// One instruction at a time: fetch a single opcode byte from program
// memory, then spend the opcode's microcycle count in execution and
// commit the result at the last microcycle tick. Only the shift, rotate,
// status and no-op codes of the group are decoded here; every other
// code falls through as a no-op of one or two bytes.
// Software loads the registers and starts or stops the core through the
// register port; loads are honoured only while the core is stopped.
module shift_status_misc_exec #(
    parameter [7:0] CLK_PER_MC = `CLK_PER_MC
) (
    input  wire        clock,
    input  wire        rst_n,
    input  wire [3:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_write,
    input  wire        reg_read,
    output reg  [7:0]  reg_rdata,
    output wire        fetch_req,
    output reg  [15:0] fetch_addr,
    input  wire        fetch_ack,
    input  wire [7:0]  fetch_data,
    input  wire        sense_a,
    input  wire        sense_b,
    input  wire        int_req,
    output reg         int_take,
    output reg         halt_flag,
    output reg  [2:0]  flag_out
);

    ////////////////////////////////////////////////////////////////////////
    // Sequencer states. The spare code 2'b11 is never entered and falls
    // back to stop through the default branch.
    localparam [1:0] S_STOP  = 2'b00;
    localparam [1:0] S_FETCH = 2'b01;
    localparam [1:0] S_EXEC  = 2'b10;

    // Sequencer and run control.
    reg  [1:0]  state;
    reg  [1:0]  next_state;
    reg         run;
    // Architectural registers seen by software.
    reg  [7:0]  work_register;
    reg  [7:0]  flag_byte;
    reg  [15:0] pc;
    // Opcode under execution and its microcycle timing.
    reg  [7:0]  opcode;
    reg  [7:0]  mc_div;
    reg         mc_tick;
    reg  [3:0]  mc_count;
    reg  [3:0]  mc_total;
    reg  [15:0] pc_step;
    // Interrupt deferral and the result committed at instruction end.
    reg         defer;
    reg  [7:0]  next_work;
    reg  [7:0]  next_flags;
    reg         next_defer;

    // Decoded and derived values.
    wire [7:0]  flags_seen;
    wire        exec_done;
    wire        known;

    // Sense bits are live inputs, never stored state. The fetch request is
    // a decode of the state, so it falls on the very edge that takes the
    // byte; the end of execution is the last tick of the last microcycle.
    assign flags_seen = {flag_byte[7:6], sense_b, sense_a, flag_byte[3:0]};
    assign fetch_req  = (state == S_FETCH);
    assign exec_done  = (state == S_EXEC) && mc_tick &&
                        (mc_count == mc_total - 4'h1);

    ////////////////////////////////////////////////////////////////////////
    // Microcycle divider: one enable pulse every CLK_PER_MC clocks.
    // The phase runs free from reset, so the first microcycle of an
    // instruction may be short by up to one period less one clock.
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mc_div  <= 8'h00;
            mc_tick <= 1'b0;
        end else if (mc_div == CLK_PER_MC - 8'h01) begin
            mc_div  <= 8'h00;
            mc_tick <= 1'b1;
        end else begin
            mc_div  <= mc_div + 8'h01;
            mc_tick <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Decode of the execution time and program counter step per opcode.
    // Unknown codes with bit 7 set are taken as two-byte no-ops, the rest
    // as one-byte no-ops; the second byte is skipped, never fetched.
    // Codes that touch the interrupt gate or load the flag byte need an
    // extra microcycle; halt needs eight to leave room for its status slot.
    assign known = (opcode == `OPC_HALT) || (opcode == `OPC_CLEAR_CARRY) ||
                   (opcode == `OPC_SET_CARRY) || (opcode == `OPC_INT_OFF) ||
                   (opcode == `OPC_INT_ON) || (opcode == `OPC_IDLE) ||
                   (opcode == `OPC_FLAGS_TO_WK) ||
                   (opcode == `OPC_WK_TO_FLAGS) ||
                   (opcode == `OPC_SHIFT_LINK) || (opcode == `OPC_ROTATE) ||
                   (opcode == `OPC_ROTATE_LINK);

    always @* begin
        pc_step = 16'h0001;
        case (opcode)
            `OPC_HALT:        mc_total = `MC_HALT;
            `OPC_INT_OFF,
            `OPC_INT_ON,
            `OPC_WK_TO_FLAGS: mc_total = `MC_GATE;
            default: begin
                if (!known && opcode[7]) begin
                    mc_total = `MC_LONG;
                    pc_step  = 16'h0002;
                end else begin
                    mc_total = `MC_SHORT;
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Effect of each instruction on the work register, flags and deferral.
    // Computed from the values as they stand before the instruction ends.
    // Rotate through link moves bit 0 into carry/link and carry/link into bit 7 in one step, so both
    // sides take the old values and no partial update is ever visible.
    // Codes outside the group leave the work register and flags as they were.
    always @* begin
        next_work  = work_register;
        next_flags = flag_byte;
        next_defer = 1'b0;
        case (opcode)
            `OPC_SHIFT_LINK: begin
                next_work = {flag_byte[`FB_CARRY], work_register[7:1]};
            end
            `OPC_ROTATE: begin
                next_work = {work_register[0], work_register[7:1]};
            end
            `OPC_ROTATE_LINK: begin
                next_work = {flag_byte[`FB_CARRY], work_register[7:1]};
                next_flags[`FB_CARRY] = work_register[0];
            end
            `OPC_CLEAR_CARRY: begin
                next_flags[`FB_CARRY] = 1'b0;
            end
            `OPC_SET_CARRY: begin
                next_flags[`FB_CARRY] = 1'b1;
            end
            `OPC_INT_ON: begin
                next_flags[`FB_GATE] = 1'b1;
                next_defer = 1'b1;
            end
            `OPC_INT_OFF: begin
                next_flags[`FB_GATE] = 1'b0;
            end
            `OPC_FLAGS_TO_WK: begin
                next_work = flags_seen;
            end
            `OPC_WK_TO_FLAGS: begin
                // Sense positions keep their old stored value.
                next_flags = (work_register & ~`FB_SENSE_MASK) |
                             (flag_byte & `FB_SENSE_MASK);
                next_defer = !flag_byte[`FB_GATE] &&
                             work_register[`FB_GATE];
            end
            default: begin
                next_work = work_register;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer: fetch one byte, then count microcycles to the end.
    // Clearing run in mid-instruction lets the instruction finish and only
    // then stops, so the registers are never left half-updated.
    always @* begin
        next_state = state;
        case (state)
            S_STOP: begin
                if (run) begin
                    next_state = S_FETCH;
                end
            end
            S_FETCH: begin
                if (fetch_ack) begin
                    next_state = S_EXEC;
                end
            end
            S_EXEC: begin
                if (exec_done) begin
                    next_state = run ? S_FETCH : S_STOP;
                end
            end
            default: begin
                next_state = S_STOP;
            end
        endcase
    end

    // Opcode and count are loaded together on the edge that takes the
    // byte, so the count always starts from zero for a fresh opcode.
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state    <= S_STOP;
            opcode   <= 8'h00;
            mc_count <= 4'h0;
        end else begin
            state <= next_state;
            if (state == S_FETCH && fetch_ack) begin
                opcode   <= fetch_data;
                mc_count <= 4'h0;
            end else if (state == S_EXEC && mc_tick) begin
                mc_count <= mc_count + 4'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Architectural state. Writes other than to control land only while the sequencer
    // is stopped, so an instruction never sees a half-updated register.
    // A load sent while running is dropped without notice; software must
    // poll the state until it reads stopped before loading.
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            run           <= 1'b0;
            work_register <= 8'h00;
            flag_byte     <= 8'h00;
            pc            <= 16'h0000;
            defer         <= 1'b0;
        end else begin
            if (reg_write && reg_addr == `REG_CONTROL) begin
                run <= reg_wdata[0];
            end
            if (exec_done) begin
                work_register <= next_work;
                flag_byte     <= next_flags;
                pc            <= pc + pc_step;
                // A deferral lasts through exactly one later instruction.
                defer         <= next_defer;
            end else if (reg_write && state == S_STOP) begin
                case (reg_addr)
                    `REG_WORK:    work_register <= reg_wdata;
                    `REG_FLAGS:   flag_byte     <= reg_wdata;
                    `REG_PC_LOW:  pc[7:0]       <= reg_wdata;
                    `REG_PC_HIGH: pc[15:8]      <= reg_wdata;
                    default:      defer         <= defer;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs: fetch address, halt pulse, interrupt take, flag pins.
    // The take pulse only fires at an instruction boundary, so a request
    // that lasts less than one instruction may be missed.
    // Every output here is registered so the far side sees clean levels;
    // the cost is one clock of latency on the flag pins.
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            fetch_addr <= 16'h0000;
            halt_flag  <= 1'b0;
            int_take   <= 1'b0;
            flag_out   <= 3'h0;
        end else begin
            // Present the advanced address on the edge that commits the
            // instruction, so it already stands when the request rises
            // and does not move while the request waits.
            fetch_addr <= exec_done ? pc + pc_step : pc;
            flag_out   <= flag_byte[2:0];
            // High for the whole I/O status microcycle of the halt code.
            halt_flag  <= (state == S_EXEC) && (opcode == `OPC_HALT) &&
                          (mc_count == `MC_IO_STATUS);
            int_take   <= exec_done && int_req &&
                          next_flags[`FB_GATE] && !next_defer;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register read port: data stands in the cycle after the strobe.
    // Unmapped addresses read as zero. Reads have no side effects, so
    // polling the state register while the core runs is always safe.
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            case (reg_addr)
                `REG_CONTROL: reg_rdata <= {7'h00, run};
                `REG_WORK:    reg_rdata <= work_register;
                `REG_FLAGS:   reg_rdata <= flags_seen;
                `REG_PC_LOW:  reg_rdata <= pc[7:0];
                `REG_PC_HIGH: reg_rdata <= pc[15:8];
                `REG_STATE:   reg_rdata <= {5'h00, defer, state};
                `REG_LAST_OP: reg_rdata <= opcode;
                default:      reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule
`default_nettype wire

// file: verilog/shift_status_misc_exec_defines.vh
// Constants for the shift, status and miscellaneous instruction executor.
// What this block does
// - 1D shifts work register right, carry/link into bit 7; 5 microcycles.
// - 1E rotates right; 1F rotates through carry/link; 5 microcycles each.
// - Opcode 00 pulses the halt flag at I/O status time; 8 microcycles.
// - Opcode 02 clears carry/link only; 5 microcycles.
// - Opcode 03 sets carry/link only; 5 microcycles.
// - 05 sets interrupt gate; service waits one instruction; 6 microcycles.
// - Opcode 04 clears interrupt gate; requests then ignored; 6 microcycles.
// - Opcode 06 copies flag byte into work register; 5 microcycles.
// - Opcode 07 loads flag byte except bits 4 and 5; 6 microcycles.
// - Gate turned on by opcode 07 defers service by one instruction.
// - Opcode 08 only advances the program counter; 5 microcycles.
// - Undefined opcodes are one- or two-byte no-ops, 5 to 10 microcycles.
`ifndef SHIFT_STATUS_MISC_EXEC_DEFINES_VH
`define SHIFT_STATUS_MISC_EXEC_DEFINES_VH

// Opcodes.
`define OPC_HALT        8'h00
`define OPC_CLEAR_CARRY 8'h02
`define OPC_SET_CARRY   8'h03
`define OPC_INT_OFF     8'h04
`define OPC_INT_ON      8'h05
`define OPC_FLAGS_TO_WK 8'h06
`define OPC_WK_TO_FLAGS 8'h07
`define OPC_IDLE        8'h08
`define OPC_SHIFT_LINK  8'h1D
`define OPC_ROTATE      8'h1E
`define OPC_ROTATE_LINK 8'h1F

// Execution times in microcycles.
`define MC_SHORT        4'h5
`define MC_GATE         4'h6
`define MC_HALT         4'h8
`define MC_LONG         4'hA
// Microcycle in which the halt flag is pulsed (I/O status time).
`define MC_IO_STATUS    4'h3
// Clocks per microcycle at 50 MHz.
`define CLK_PER_MC      8'h32

// Flag byte bit positions.
`define FB_CARRY        7
`define FB_OVERFLOW     6
`define FB_SENSE_B      5
`define FB_SENSE_A      4
`define FB_GATE         3
// Bits that software may not write through the load instruction.
`define FB_SENSE_MASK   8'h30

// Register port addresses.
`define REG_CONTROL     4'h0
`define REG_WORK        4'h1
`define REG_FLAGS       4'h2
`define REG_PC_LOW      4'h3
`define REG_PC_HIGH     4'h4
`define REG_STATE       4'h5
`define REG_LAST_OP     4'h6

`endif
